// >>> logic/swk_pkg.sv
// swk_pkg: register map, field layout, reset values and carrier types
// for the selective-wake configuration block; used by logic and bench.
`default_nettype none
package swk_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_CTRL      = 8'h20;
  localparam logic [7:0] IDX_BTL1      = 8'h21;
  localparam logic [7:0] IDX_BTL2      = 8'h22;
  localparam logic [7:0] IDX_ID3       = 8'h23;
  localparam logic [7:0] IDX_ID2       = 8'h24;
  localparam logic [7:0] IDX_ID1       = 8'h25;
  localparam logic [7:0] IDX_ID0       = 8'h26;
  localparam logic [7:0] IDX_MASK3     = 8'h27;
  localparam logic [7:0] IDX_MASK2     = 8'h28;
  localparam logic [7:0] IDX_MASK1     = 8'h29;
  localparam logic [7:0] IDX_MASK0     = 8'h2a;
  localparam logic [7:0] IDX_OPT       = 8'h30;
  localparam logic [7:0] IDX_CDR2      = 8'h31;
  localparam logic [7:0] IDX_STATUS    = 8'h32;
  // control register fields
  localparam int        CTRL_TRIM_BIT  = 7;
  localparam int        CTRL_KEY_HI    = 6;
  localparam int        CTRL_KEY_LO    = 5;
  localparam int        CTRL_TOIE_BIT  = 4;
  localparam int        CTRL_VALID_BIT = 0;
  localparam logic [1:0] KEY_UNLOCK    = 2'h3;
  localparam logic [7:0] CTRL_WMASK    = 8'hf1;
  localparam logic [7:0] CTRL_KEEP_RESTART = 8'hf0;
  localparam logic [7:0] SP_WMASK      = 8'h3f;
  localparam logic [7:0] ID0_WMASK     = 8'h7f;
  localparam logic [7:0] MASK0_WMASK   = 8'h7c;
  localparam logic [7:0] CDR2_WMASK    = 8'h03;
  // reset values
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam logic [7:0] RST_BTL1      = 8'ha0;
  localparam logic [7:0] RST_BTL2      = 8'h33;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  // sample quantum of the reset timing, so the matcher view is consistent in reset
  localparam logic [7:0] RST_QUANTUM   = 8'((16'(RST_BTL1) * 16'(RST_BTL2[5:0])) >> 6);
  // status register bit positions
  localparam int        ST_TIMEOUT_BIT = 0;
  localparam int        ST_ENABLED_BIT = 1;
  localparam int        ST_UNLOCK_BIT  = 2;

  // configuration handed to the wake-frame matcher
  typedef struct packed {
    logic [28:0] frame_id;
    logic [28:0] frame_id_mask;
    logic        remote_request_bit;
    logic        extended_format_select;
    logic [7:0]  quanta_per_bit;
    logic [5:0]  sample_fraction;
    logic [7:0]  sample_quantum;
    logic [1:0]  quantum_clock_select;
    logic [7:0]  low_power_receiver_options;
  } swk_cfg_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] btl1;
    logic [7:0] btl2;
    logic [7:0] id3;
    logic [7:0] id2;
    logic [7:0] id1;
    logic [7:0] id0;
    logic [7:0] mask3;
    logic [7:0] mask2;
    logic [7:0] mask1;
    logic [7:0] mask0;
    logic [7:0] opt;
    logic [7:0] cdr2;
    logic       timeout_flag;
  } swk_regs_t;
endpackage
`default_nettype wire

// >>> logic/swk_config.sv
// swk_config: selective-wake control and configuration registers behind
// an AHB-Lite slave. Assumes one master, word transfers, one clock hclk.
// Mode events (restart, wake, bus time-out) arrive from same-clock logic.
//
// Overview of operation
// - top control bit enables oscillator calibration
// - calibration unlocks only when key equals 11
// - trimming syncs to the can transmit input
// - receiver option writes accepted only when unlocked
// - time-out drives interrupt only when enabled
// - time-out flag updates only with selective wake
// - control bits three to one read zero
// - selective wake enabled only with valid bit
// - valid clears on wake, reset, config change
// - restart clears control low nibble only
// - eight-bit quanta per bit time field
// - quanta reset a0, kept through restart
// - quantum length set by clock select field
// - six-bit sample fraction, top bits read zero
// - sample point resets to 33
// - first id register holds bits 28..21
// - second id register holds bits 20..13
// - third id register holds bits 12..5
// - standard ids sit in positions 28..18
// - mask bit one means identifier bit compared
// - low id register: id4..0, rtr, ide
`default_nettype none
module swk_config
  import swk_pkg::*;
(
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // device mode events, same clock; restart and wake are one-cycle pulses, selective_wake_mode a level
  input  wire logic             restart_entry,
  input  wire logic             wake_event,
  input  wire logic             bus_timeout_event,
  input  wire logic             selective_wake_mode,
  // pin from host, asynchronous
  input  wire logic             can_transmit_input,
  // outputs to the rest of the device
  output logic                  oscillator_trim_enable,
  output logic                  trim_sync,
  output logic                  selective_wake_enable,
  output logic                  bus_timeout_irq,
  output swk_pkg::swk_cfg_t     wake_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  import swk_pkg::*;

  typedef struct packed {
    swk_regs_t  r;
    logic       ph_wr;
    logic [7:0] ph_idx;
    logic [31:0] rdata;
    logic       trim_en;
    logic       trim_sync;
    logic       swk_en;
    logic       irq;
    swk_cfg_t   cfg;
    logic [1:0] txd_sync;
  } swk_state_t;

  swk_state_t s;
  swk_state_t next_s;

  logic        addr_ok;
  logic [7:0]  addr_idx;
  logic [7:0]  wd;
  logic        unlocked;
  logic        cfg_change;
  logic        rd_take;
  logic [13:0] sp_product;

  // index from byte address; only aligned words inside the map decode
  assign addr_idx = haddr[9:2];
  assign addr_ok  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign wd       = hwdata[7:0];
  // reads are answered from the address phase so hrdata stands in the data phase
  assign rd_take  = hsel && hready && htrans[1] && !hwrite && addr_ok;
  assign unlocked = (s.r.ctrl[CTRL_KEY_HI:CTRL_KEY_LO] == KEY_UNLOCK);
  // sample quantum = quanta * fraction / 64, truncated
  assign sp_product = s.r.btl1 * s.r.btl2[5:0];

  // next state: bus phases, register writes, events and derived outputs
  always_comb begin
    next_s     = s;
    cfg_change = 1'b0;
    // address phase capture; the slave is always ready
    next_s.ph_wr  = hsel && hready && htrans[1] && hwrite && addr_ok;
    next_s.ph_idx = addr_idx;
    next_s.rdata  = 32'h00000000;
    // data phase write
    if (s.ph_wr) begin
      case (s.ph_idx)
        IDX_CTRL: begin
          // valid bit written by host; all other fields plain storage
          next_s.r.ctrl = wd & CTRL_WMASK;
        end
        IDX_BTL1:  begin next_s.r.btl1  = wd;               cfg_change = 1'b1; end
        IDX_BTL2:  begin next_s.r.btl2  = wd & SP_WMASK;    cfg_change = 1'b1; end
        IDX_ID3:   begin next_s.r.id3   = wd;               cfg_change = 1'b1; end
        IDX_ID2:   begin next_s.r.id2   = wd;               cfg_change = 1'b1; end
        IDX_ID1:   begin next_s.r.id1   = wd;               cfg_change = 1'b1; end
        IDX_ID0:   begin next_s.r.id0   = wd & ID0_WMASK;   cfg_change = 1'b1; end
        IDX_MASK3: begin next_s.r.mask3 = wd;               cfg_change = 1'b1; end
        IDX_MASK2: begin next_s.r.mask2 = wd;               cfg_change = 1'b1; end
        IDX_MASK1: begin next_s.r.mask1 = wd;               cfg_change = 1'b1; end
        IDX_MASK0: begin next_s.r.mask0 = wd & MASK0_WMASK; cfg_change = 1'b1; end
        IDX_OPT: begin
          // locked writes are dropped silently
          if (unlocked) begin
            next_s.r.opt = wd;
          end
        end
        IDX_CDR2:  begin next_s.r.cdr2  = wd & CDR2_WMASK;  cfg_change = 1'b1; end
        default: begin
        end
      endcase
    end
    // a config write other than to the option register, or a wake, drops validity, overriding a host set
    if (cfg_change || wake_event) begin
      next_s.r.ctrl[CTRL_VALID_BIT] = 1'b0;
    end
    // restart keeps the upper nibble, other registers keep their value
    if (restart_entry) begin
      next_s.r.ctrl = s.r.ctrl & CTRL_KEEP_RESTART;
    end
    // flag tracks time-out only while selective wake mode is on
    if (selective_wake_mode) begin
      next_s.r.timeout_flag = bus_timeout_event;
    end
    // read mux on the updated registers: a read right after a write sees the new
    // value; reserved bits are masked at write time so they read zero
    if (rd_take) begin
      case (addr_idx)
        IDX_CTRL:   next_s.rdata[7:0] = next_s.r.ctrl;
        IDX_BTL1:   next_s.rdata[7:0] = next_s.r.btl1;
        IDX_BTL2:   next_s.rdata[7:0] = next_s.r.btl2;
        IDX_ID3:    next_s.rdata[7:0] = next_s.r.id3;
        IDX_ID2:    next_s.rdata[7:0] = next_s.r.id2;
        IDX_ID1:    next_s.rdata[7:0] = next_s.r.id1;
        IDX_ID0:    next_s.rdata[7:0] = next_s.r.id0;
        IDX_MASK3:  next_s.rdata[7:0] = next_s.r.mask3;
        IDX_MASK2:  next_s.rdata[7:0] = next_s.r.mask2;
        IDX_MASK1:  next_s.rdata[7:0] = next_s.r.mask1;
        IDX_MASK0:  next_s.rdata[7:0] = next_s.r.mask0;
        IDX_OPT:    next_s.rdata[7:0] = next_s.r.opt;
        IDX_CDR2:   next_s.rdata[7:0] = next_s.r.cdr2;
        IDX_STATUS: begin
          next_s.rdata[ST_TIMEOUT_BIT] = next_s.r.timeout_flag;
          next_s.rdata[ST_ENABLED_BIT] = s.swk_en;
          next_s.rdata[ST_UNLOCK_BIT]  = unlocked;
        end
        default:    next_s.rdata = 32'h00000000;
      endcase
    end
    // outputs from the registered state
    next_s.trim_en   = s.r.ctrl[CTRL_TRIM_BIT] && unlocked;
    next_s.txd_sync  = {s.txd_sync[0], can_transmit_input};
    next_s.trim_sync = s.trim_en && s.txd_sync[1];
    next_s.swk_en    = s.r.ctrl[CTRL_VALID_BIT] && selective_wake_mode;
    next_s.irq       = s.r.timeout_flag && s.r.ctrl[CTRL_TOIE_BIT];
    // matcher view; standard ids live in positions 28..18
    next_s.cfg.frame_id      = {s.r.id3, s.r.id2, s.r.id1, s.r.id0[6:2]};
    next_s.cfg.frame_id_mask = {s.r.mask3, s.r.mask2, s.r.mask1, s.r.mask0[6:2]};
    next_s.cfg.remote_request_bit     = s.r.id0[1];
    next_s.cfg.extended_format_select = s.r.id0[0];
    next_s.cfg.quanta_per_bit         = s.r.btl1;
    next_s.cfg.sample_fraction        = s.r.btl2[5:0];
    next_s.cfg.sample_quantum         = sp_product[13:6];
    next_s.cfg.quantum_clock_select   = s.r.cdr2[1:0];
    next_s.cfg.low_power_receiver_options = s.r.opt;
  end

  // single state register; reset gives power-on / soft reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s        <= '0;
      s.r.ctrl <= RST_CTRL;
      s.r.btl1 <= RST_BTL1;
      s.r.btl2 <= RST_BTL2;
      s.cfg.quanta_per_bit  <= RST_BTL1;
      s.cfg.sample_fraction <= RST_BTL2[5:0];
      s.cfg.sample_quantum  <= RST_QUANTUM;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata                 = s.rdata;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign oscillator_trim_enable = s.trim_en;
  assign trim_sync              = s.trim_sync;
  assign selective_wake_enable  = s.swk_en;
  assign bus_timeout_irq        = s.irq;
  assign wake_cfg               = s.cfg;
endmodule
`default_nettype wire

// >>> sim/swk_config_asserts.sv
// swk_config_asserts: port-level checks of the selective-wake register block
// assumes the bind below, one clock hclk and the async active-low hresetn
`default_nettype none
module swk_config_asserts
  import swk_pkg::*;
(
  // clock, reset and bus
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // events and outputs
  input wire logic              wake_event,
  input wire logic              restart_entry,
  input wire logic              selective_wake_mode,
  input wire logic              can_transmit_input,
  input wire logic              oscillator_trim_enable,
  input wire logic              trim_sync,
  input wire logic              selective_wake_enable,
  input wire swk_pkg::swk_cfg_t wake_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       wr_ctrl;
  logic [2:0] trim_sh;
  logic [7:0] rd_idx;
  // shadow of the trim and key bits rebuilt from bus writes; restart never touches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl <= 1'h0;
      trim_sh <= 3'h0;
      rd_idx  <= 8'h00;
    end else begin
      if (wr_ctrl) trim_sh <= hwdata[7:5];
      wr_ctrl <= hsel && hready && htrans[1] && hwrite && haddr == 32'h80;
      rd_idx  <= (hsel && hready && htrans[1] && !hwrite) ? haddr[9:2] : 8'h00;
    end
  end
  property p_okay; hreadyout && !hresp; endproperty
  property p_trim; oscillator_trim_enable && $stable(trim_sh) |-> trim_sh == 3'h7; endproperty
  property p_opt; $changed(wake_cfg.low_power_receiver_options) |-> $past(trim_sh[1:0]) == KEY_UNLOCK; endproperty
  // two sync flops plus the output flop: pin seen three edges back, enable one
  property p_sync; trim_sync == ($past(oscillator_trim_enable) && $past(can_transmit_input, 3)); endproperty
  property p_valid; selective_wake_enable |-> $past(selective_wake_mode); endproperty
  property p_wake; wake_event |-> ##2 !selective_wake_enable; endproperty
  property p_restart; restart_entry |-> ##2 !selective_wake_enable; endproperty
  property p_rdzero;
    rd_idx != 8'h00 |-> hrdata[31:8] == 24'h0 && (rd_idx != IDX_CTRL || hrdata[3:1] == 3'h0)
      && (rd_idx != IDX_BTL2 || hrdata[7:6] == 2'h0);
  endproperty
  property p_quantum;
    wake_cfg.sample_quantum == 8'((16'(wake_cfg.quanta_per_bit) * 16'(wake_cfg.sample_fraction)) >> 6);
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
  a_trim: assert property (p_trim) else $error("trim enable without full key");
  a_opt: assert property (p_opt) else $error("option register changed while locked");
  a_sync: assert property (p_sync) else $error("trim sync not following pin");
  a_valid: assert property (p_valid) else $error("wake enable outside wake mode");
  a_wake: assert property (p_wake) else $error("valid bit kept after wake");
  a_restart: assert property (p_restart) else $error("valid bit kept after restart");
  a_rdzero: assert property (p_rdzero) else $error("reserved bits read nonzero");
  a_quantum: assert property (p_quantum) else $error("sample quantum wrong");
  c_trim: cover property (oscillator_trim_enable);
  c_wake: cover property (selective_wake_enable ##1 wake_event);
  c_opt: cover property ($changed(wake_cfg.low_power_receiver_options));
endmodule
bind swk_config swk_config_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .wake_event, .restart_entry, .selective_wake_mode, .can_transmit_input,
  .oscillator_trim_enable, .trim_sync, .selective_wake_enable, .wake_cfg);
`default_nettype wire

// >>> sim/swk_host_model.sv
// swk_host_model: host side of the trim reference pin
// assumes the bench raises trim_req only while calibration is unlocked
`default_nettype none
module swk_host_model (
  input  wire logic hclk,
  input  wire logic trim_req,
  output var  logic can_transmit_input = 1'h1
);
  timeunit 1ns;
  timeprecision 1ps;
  // toggles a reference while trimming, otherwise rests at the recessive level
  always @(posedge hclk)
    can_transmit_input <= trim_req ? ~can_transmit_input : 1'h1;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// testbench: drives the register block over the bus and checks reads and outputs
// assumes the checker is bound to the design and the host model drives the trim pin
`default_nettype none
module testbench
  import swk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, trim_req = 1'h0;
  logic        restart_entry = 1'h0, wake_event = 1'h0, bus_timeout_event = 1'h0, selective_wake_mode = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, id;
  logic        hreadyout, hresp, can_transmit_input, oscillator_trim_enable, trim_sync;
  logic        selective_wake_enable, bus_timeout_irq, rdp = 1'h0;
  swk_cfg_t    wake_cfg;
  logic [31:0] exp_q[$];
  int          n_fail = 0, num_checks = 0;
  logic [7:0]  rst_v[6] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00};
  swk_config u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .restart_entry, .wake_event, .bus_timeout_event, .selective_wake_mode,
    .can_transmit_input, .oscillator_trim_enable, .trim_sync, .selective_wake_enable, .bus_timeout_irq, .wake_cfg);
  swk_host_model u_host (.hclk, .trim_req, .can_transmit_input);
  always #2.5 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; waits on hready rather than assuming zero wait states
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'h0, idx, 32'h0);
  endtask
  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read monitor: the data phase carries the answer, matched to the oldest note
  always @(posedge hclk) begin
    if (rdp && hreadyout === 1'h1) chk(hrdata, exp_q.pop_front());
    rdp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_fail++;
    end_sim;
  end
  initial begin
    void'($urandom(83));
    repeat (5) @(posedge hclk);
    chk(wake_cfg.quanta_per_bit, 8'ha0);
    chk(wake_cfg.sample_fraction, 6'h33);
    hresetn <= 1'h1;
    @(posedge hclk);
    foreach (rst_v[i]) rd(IDX_CTRL + 8'(i), {24'h0, rst_v[i]});
    id = $urandom;
    for (int i = 0; i < 3; i++) bus(1'h1, IDX_ID3 + 8'(i), {24'h0, id[23-8*i -: 8]});
    bus(1'h1, IDX_ID0, {24'h0, id[31:24]});
    bus(1'h1, IDX_MASK0, 32'hff);
    rd(IDX_ID2, {24'h0, id[15:8]});
    bus(1'h1, IDX_BTL1, id);
    bus(1'h1, IDX_BTL2, 32'hff);
    rd(IDX_BTL2, 32'h3f);
    bus(1'h1, IDX_CDR2, 32'h2);
    settle;
    chk(wake_cfg.frame_id[28:5], id[23:0]);
    chk(wake_cfg.quanta_per_bit, id[7:0]);
    chk(wake_cfg.sample_quantum, 8'((16'(id[7:0]) * 16'h3f) >> 6));
    chk(wake_cfg.quantum_clock_select, 2'h2);
    chk(wake_cfg.frame_id[4:0], {27'h0, id[30:26]});
    chk({wake_cfg.remote_request_bit, wake_cfg.extended_format_select}, {30'h0, id[25:24]});
    chk(wake_cfg.frame_id_mask[4:0], 5'h1f);
    bus(1'h1, IDX_OPT, 32'h5a);
    bus(1'h1, IDX_CTRL, 32'hff);
    rd(IDX_CTRL, 32'hf1);
    trim_req <= 1'h1;
    settle;
    chk({oscillator_trim_enable, wake_cfg.low_power_receiver_options}, 9'h100);
    bus(1'h1, IDX_OPT, 32'h5a);
    bus(1'h1, IDX_CTRL, 32'hd1);
    trim_req <= 1'h0;
    settle;
    chk({oscillator_trim_enable, wake_cfg.low_power_receiver_options}, 9'h05a);
    selective_wake_mode <= 1'h1;
    bus(1'h1, IDX_CTRL, 32'h11);
    bus_timeout_event <= 1'h1;
    settle;
    chk({bus_timeout_irq, selective_wake_enable}, 2'h3);
    selective_wake_mode <= 1'h0;
    @(posedge hclk) bus_timeout_event <= 1'h0;
    settle;
    chk({bus_timeout_irq, selective_wake_enable}, 2'h2);
    bus(1'h1, IDX_CTRL, 32'h01);
    selective_wake_mode <= 1'h1;
    bus_timeout_event <= 1'h1;
    settle;
    chk({bus_timeout_irq, selective_wake_enable}, 2'h1);
    bus_timeout_event <= 1'h0;
    bus(1'h1, IDX_ID1, 32'h12);
    rd(IDX_CTRL, 32'h00);
    bus(1'h1, IDX_CTRL, 32'h01);
    wake_event <= 1'h1;
    @(posedge hclk) wake_event <= 1'h0;
    settle;
    chk(selective_wake_enable, 1'h0);
    bus(1'h1, IDX_CTRL, 32'hf1);
    restart_entry <= 1'h1;
    @(posedge hclk) restart_entry <= 1'h0;
    rd(IDX_CTRL, 32'hf0);
    rd(IDX_BTL1, {24'h0, id[7:0]});
    rd(IDX_STATUS, 32'h04);
    bus(1'h1, 8'hff, 32'hff);
    rd(8'hff, 32'h0);
    settle;
    chk(exp_q.size(), 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
